// File: core/ramp_event_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "ramp_evt_defs.vh"
module ramp_event_ctrl (
	input  wire        CORE_CLK,
	input  wire        RST,
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output reg  [31:0] HRDATA,
	output reg         HREADYOUT,
	output reg         HRESP,
	input  wire [1:0]  REF_L,
	input  wire [1:0]  REF_R,
	input  wire [1:0]  STALL_IN,
	output reg  [1:0]  IRQ,
	output wire [1:0]  STEP,
	output wire [1:0]  DIR,
	output reg  [3:0]  VEL_RANGE
);
	localparam B_IDLE = 1'b0;
	localparam B_DATA = 1'b1;

	// ****************************************
	// shared decode
	// ****************************************
	function hit;
		input [31:0] a;
		input integer ax;
		input [5:0]  o;
		begin
			hit = (a[31:`AXIS_BIT+1] == 0) && (a[`AXIS_BIT] == ax[0]) && (a[5:0] == o);
		end
	endfunction

	function vcmp;
		input [23:0] v;
		input [23:0] t;
		begin
			vcmp = v[23:`THR_LSB] >= t[23:`THR_LSB];
		end
	endfunction

	// ****************************************
	// ahb-lite slave, one wait state per transfer
	// ****************************************
	reg         bst_r;
	reg         wr_q_r;
	reg         ok_q_r;
	reg  [31:0] addr_q_r;
	wire        take;
	wire        wr_p;
	wire        rd_p;
	wire        mapped;
	wire [63:0] rd_all;
	wire [31:0] rd_sel;

	assign take   = HSEL & HTRANS[`HTRANS_ACT_BIT] & HREADY & (bst_r == B_IDLE);
	assign wr_p   = (bst_r == B_DATA) & wr_q_r & ok_q_r;
	assign rd_p   = (bst_r == B_DATA) & ~wr_q_r & ok_q_r;
	assign mapped = (addr_q_r[31:`AXIS_BIT+1] == 0);
	assign rd_sel = addr_q_r[`AXIS_BIT] ? rd_all[63:32] : rd_all[31:0];

	// the wait state lets read data and read-clear come from flops in one cycle
	always @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			bst_r     <= B_IDLE;
			wr_q_r    <= 1'b0;
			ok_q_r    <= 1'b0;
			addr_q_r  <= 32'h00000000;
			HRDATA    <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP     <= `HRESP_OKAY;
		end
		else
		begin
			HRESP <= `HRESP_OKAY;
			case (bst_r)
			B_IDLE:
			begin
				if (take)
				begin
					bst_r     <= B_DATA;
					HREADYOUT <= 1'b0;
					wr_q_r    <= HWRITE;
					ok_q_r    <= (HSIZE == `HSIZE_WORD);
					addr_q_r  <= HADDR;
				end
			end
			B_DATA:
			begin
				bst_r     <= B_IDLE;
				HREADYOUT <= 1'b1;
				HRDATA    <= (rd_p & mapped) ? rd_sel : 32'h00000000;
			end
			default:
			begin
				bst_r     <= B_IDLE;
				HREADYOUT <= 1'b1;
			end
			endcase
		end
	end

	// ****************************************
	// ramp tick divider
	// ****************************************
	reg [6:0] div_r;
	reg       tick_r;

	always @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			div_r  <= 7'h00;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= (div_r == `TICK_DIV);
			div_r  <= (div_r == `TICK_DIV) ? 7'h00 : div_r + 7'h01;
		end
	end

	// ****************************************
	// switch and stall input conditioning
	// ****************************************
	wire [5:0] act;
	wire [5:0] pol_w;
	wire [1:0] irq_w;
	wire [3:0] range_w;

	ref_input_sync #(
		.W   (6)
	) u_sync (
		.clk   (CORE_CLK),
		.rst   (RST),
		.raw   ({STALL_IN, REF_R, REF_L}),
		.pol   (pol_w),
		.act_r (act)
	);

	always @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			IRQ       <= 2'h0;
			VEL_RANGE <= 4'h0;
		end
		else
		begin
			IRQ       <= irq_w;
			VEL_RANGE <= range_w;
		end
	end

	// ****************************************
	// per-axis ramp, stop and event logic
	// ****************************************
	genvar i;
	generate
	for (i = 0; i < `AXES; i = i + 1)
	begin : ax
		reg  [1:0]         mode_r;
		reg  [31:0]        xtgt_r;
		reg  [22:0]        max_velocity_r;
		reg  [15:0]        amax_r;
		reg  [15:0]        max_deceleration_r;
		reg  [15:0]        d1_r;
		reg  [19:0]        v1_r;
		reg  [7:0]         swm_r;
		reg  [15:0]        zwd_r;
		reg  [23:0]        thra_r;
		reg  [23:0]        thrb_r;
		reg  [31:0]        latch_r;
		reg  signed [23:0] vel_r;
		reg  [15:0]        zw_cnt_r;
		reg                ev_l_r;
		reg                ev_r_r;
		reg                ev_sg_r;
		reg                ev_pos_r;
		reg                at_tgt_q_r;
		reg                stop_q_r;
		reg                sw_l_q_r;
		reg                sw_r_q_r;
		reg  signed [24:0] tv;
		reg  signed [24:0] cur;
		reg  signed [24:0] up;
		reg  signed [24:0] dn;
		reg  [15:0]        rate;
		reg  signed [23:0] vel_nxt;
		reg  [31:0]        rd;
		wire [31:0]        pos;
		wire [23:0]        absv;
		wire               sw_l;
		wire               sw_r;
		wire               stall;
		wire               clr;
		wire               set_l;
		wire               set_r;
		wire               set_sg;
		wire               stop_hold;
		wire               hard;
		wire               at_tgt;
		wire               zw_act;
		wire               block;
		wire               vzero;

		assign sw_l      = act[i];
		assign sw_r      = act[2+i];
		assign stall     = act[4+i];
		assign pol_w[i]   = swm_r[`SWM_POL_L];
		assign pol_w[2+i] = swm_r[`SWM_POL_R];
		assign pol_w[4+i] = 1'b0;
		// status read of this axis only; host must read status before position
		assign clr       = rd_p & hit(addr_q_r, i, `OFS_STAT);
		assign set_l     = swm_r[`SWM_STOP_L] & sw_l;
		assign set_r     = swm_r[`SWM_STOP_R] & sw_r;
		assign set_sg    = swm_r[`SWM_SG_EN] & stall;
		assign stop_hold = ev_l_r | ev_r_r | ev_sg_r;
		assign hard      = (stop_hold | set_l | set_r | set_sg) & ~swm_r[`SWM_SOFT];
		assign at_tgt    = (mode_r == `MODE_POS) & (pos == xtgt_r);
		assign zw_act    = (zw_cnt_r != 16'h0000);
		// steps are gated in the same cycle as a hard stop so the latch matches position
		assign block     = hard | (mode_r == `MODE_HOLD) | at_tgt;
		assign vzero     = (vel_r == 24'h000000);
		assign absv      = vel_r[23] ? (~vel_r + `VEL_ONE) : vel_r;
		assign irq_w[i]  = ev_l_r | ev_r_r | ev_sg_r | ev_pos_r;
		assign range_w[2*i]   = vcmp(absv, thra_r);
		assign range_w[2*i+1] = vcmp(absv, thrb_r);
		assign rd_all[32*i +: 32] = rd;

		always @*
		begin
			case (mode_r)
			`MODE_POS:
				if (at_tgt)
					tv = 25'h0000000;
				else if ($signed(xtgt_r) > $signed(pos))
					tv = {2'h0, max_velocity_r};
				else
					tv = -{2'h0, max_velocity_r};
			`MODE_VPOS: tv = {2'h0, max_velocity_r};
			`MODE_VNEG: tv = -{2'h0, max_velocity_r};
			default:    tv = 25'h0000000;
			endcase
			if (stop_hold | zw_act)
				tv = 25'h0000000;
			rate = amax_r;
			if (stop_hold & swm_r[`SWM_SOFT])
				rate = vcmp(absv, {4'h0, v1_r}) ? max_deceleration_r : d1_r;
			cur = {vel_r[23], vel_r};
			up  = cur + $signed({9'h000, rate});
			dn  = cur - $signed({9'h000, rate});
			if (cur < tv)
				vel_nxt = (up > tv) ? tv[23:0] : up[23:0];
			else if (cur > tv)
				vel_nxt = (dn < tv) ? tv[23:0] : dn[23:0];
			else
				vel_nxt = vel_r;
		end

		always @*
		begin
			rd = 32'h00000000;
			case (addr_q_r[5:0])
			`OFS_MODE:  rd[1:0]  = mode_r;
			`OFS_XPOS:  rd       = pos;
			`OFS_VACT:  rd       = {{8{vel_r[23]}}, vel_r};
			`OFS_MAX_VELOCITY:  rd[22:0] = max_velocity_r;
			`OFS_AMAX:  rd[15:0] = amax_r;
			`OFS_MAX_DECELERATION:  rd[15:0] = max_deceleration_r;
			`OFS_D1:    rd[15:0] = d1_r;
			`OFS_V1:    rd[19:0] = v1_r;
			`OFS_XTGT:  rd       = xtgt_r;
			`OFS_SWM:   rd[7:0]  = swm_r;
			`OFS_ZWD:   rd[15:0] = zwd_r;
			`OFS_LATCH: rd       = latch_r;
			`OFS_THRA:  rd[23:0] = thra_r;
			`OFS_THRB:  rd[23:0] = thrb_r;
			`OFS_STAT:
			begin
				rd[`ST_REF_L]      = sw_l;
				rd[`ST_REF_R]      = sw_r;
				rd[`ST_EV_L]       = ev_l_r;
				rd[`ST_EV_R]       = ev_r_r;
				rd[`ST_EV_SG]      = ev_sg_r;
				rd[`ST_EV_POS]     = ev_pos_r;
				rd[`ST_VEL_REACH]  = (cur == tv);
				rd[`ST_POS_REACH]  = at_tgt;
				rd[`ST_VZERO]      = vzero;
				rd[`ST_ZWAIT]      = zw_act;
				rd[`ST_STANDSTILL] = vzero & ~zw_act & (tv == 25'h0000000);
				rd[`ST_STALL]      = stall;
			end
			default:    rd = 32'h00000000;
			endcase
		end

		always @(posedge CORE_CLK or posedge RST)
		begin
			if (RST)
			begin
				mode_r     <= `RST_MODE;
				xtgt_r     <= 32'h00000000;
				max_velocity_r     <= 23'h000000;
				amax_r     <= `RST_AMAX;
				max_deceleration_r     <= `RST_DEC;
				d1_r       <= `RST_DEC;
				v1_r       <= 20'h00000;
				swm_r      <= `RST_SWM;
				zwd_r      <= `RST_ZWD;
				thra_r     <= 24'h000000;
				thrb_r     <= 24'h000000;
				latch_r    <= 32'h00000000;
				vel_r      <= 24'h000000;
				zw_cnt_r   <= 16'h0000;
				ev_l_r     <= 1'b0;
				ev_r_r     <= 1'b0;
				ev_sg_r    <= 1'b0;
				ev_pos_r   <= 1'b0;
				at_tgt_q_r <= 1'b0;
				stop_q_r   <= 1'b0;
				sw_l_q_r   <= 1'b0;
				sw_r_q_r   <= 1'b0;
			end
			else
			begin
				if (wr_p & hit(addr_q_r, i, `OFS_MODE))
					mode_r <= HWDATA[1:0];
				if (wr_p & hit(addr_q_r, i, `OFS_XTGT))
					xtgt_r <= HWDATA;
				if (wr_p & hit(addr_q_r, i, `OFS_MAX_VELOCITY))
					max_velocity_r <= HWDATA[22:0];
				if (wr_p & hit(addr_q_r, i, `OFS_AMAX))
					amax_r <= HWDATA[15:0];
				if (wr_p & hit(addr_q_r, i, `OFS_MAX_DECELERATION))
					max_deceleration_r <= HWDATA[15:0];
				if (wr_p & hit(addr_q_r, i, `OFS_D1))
					d1_r <= HWDATA[15:0];
				if (wr_p & hit(addr_q_r, i, `OFS_V1))
					v1_r <= HWDATA[19:0];
				if (wr_p & hit(addr_q_r, i, `OFS_SWM))
					swm_r <= HWDATA[7:0];
				if (wr_p & hit(addr_q_r, i, `OFS_ZWD))
					zwd_r <= HWDATA[15:0];
				if (wr_p & hit(addr_q_r, i, `OFS_THRA))
					thra_r <= HWDATA[23:0];
				if (wr_p & hit(addr_q_r, i, `OFS_THRB))
					thrb_r <= HWDATA[23:0];
				// a new event in the clearing cycle survives the read
				ev_l_r   <= set_l | (ev_l_r & ~clr);
				ev_r_r   <= set_r | (ev_r_r & ~clr);
				ev_sg_r  <= set_sg | (ev_sg_r & ~clr);
				ev_pos_r <= (at_tgt & ~at_tgt_q_r) | (ev_pos_r & ~clr);
				at_tgt_q_r <= at_tgt;
				stop_q_r   <= stop_hold;
				sw_l_q_r   <= sw_l;
				sw_r_q_r   <= sw_r;
				if (swm_r[`SWM_LATCH_L] & sw_l & ~sw_l_q_r)
					latch_r <= pos;
				else if (swm_r[`SWM_LATCH_R] & sw_r & ~sw_r_q_r)
					latch_r <= pos;
				// restart waits so the host can enter hold first
				if (stop_q_r & ~stop_hold)
					zw_cnt_r <= zwd_r;
				else if (tick_r & zw_act)
					zw_cnt_r <= zw_cnt_r - 16'h0001;
				if (block)
					vel_r <= 24'h000000;
				else if (tick_r)
					vel_r <= vel_nxt;
			end
		end

		step_position_counter u_step (
			.clk        (CORE_CLK),
			.rst        (RST),
			.velocity   (vel_r),
			.block      (block),
			.load       (wr_p & hit(addr_q_r, i, `OFS_XPOS)),
			.load_value (HWDATA),
			.position_r (pos),
			.step_r     (STEP[i]),
			.dir_r      (DIR[i])
		);
	end
	endgenerate
endmodule // ramp_event_ctrl
`default_nettype wire

// File: core/ramp_evt_defs.vh
`ifndef RAMP_EVT_DEFS_VH
`define RAMP_EVT_DEFS_VH
// ****************************************
// sizes and timing
// ****************************************
`define AXES           2
`define TICK_DIV       7'h63
`define THR_LSB        8
`define VEL_ONE        24'h000001
`define POS_ONE        32'h00000001
// ****************************************
// bus decode
// ****************************************
`define AXIS_BIT       6
`define HTRANS_ACT_BIT 1
`define HSIZE_WORD     3'h2
`define HRESP_OKAY     1'h0
// ****************************************
// register byte offsets inside one axis window
// ****************************************
`define OFS_MODE       6'h00
`define OFS_XPOS       6'h04
`define OFS_VACT       6'h08
`define OFS_MAX_VELOCITY       6'h0C
`define OFS_AMAX       6'h10
`define OFS_MAX_DECELERATION       6'h14
`define OFS_D1         6'h18
`define OFS_V1         6'h1C
`define OFS_XTGT       6'h20
`define OFS_SWM        6'h24
`define OFS_ZWD        6'h28
`define OFS_STAT       6'h2C
`define OFS_LATCH      6'h30
`define OFS_THRA       6'h34
`define OFS_THRB       6'h38
// ****************************************
// ramp modes
// ****************************************
`define MODE_POS       2'h0
`define MODE_VPOS      2'h1
`define MODE_VNEG      2'h2
`define MODE_HOLD      2'h3
// ****************************************
// switch mode fields
// ****************************************
`define SWM_STOP_L     0
`define SWM_STOP_R     1
`define SWM_POL_L      2
`define SWM_POL_R      3
`define SWM_LATCH_L    4
`define SWM_LATCH_R    5
`define SWM_SG_EN      6
`define SWM_SOFT       7
// ****************************************
// status fields
// ****************************************
`define ST_REF_L       0
`define ST_REF_R       1
`define ST_EV_L        2
`define ST_EV_R        3
`define ST_EV_SG       4
`define ST_EV_POS      5
`define ST_VEL_REACH   6
`define ST_POS_REACH   7
`define ST_VZERO       8
`define ST_ZWAIT       9
`define ST_STANDSTILL  10
`define ST_STALL       11
// ****************************************
// reset values
// ****************************************
`define RST_MODE       2'h3
`define RST_AMAX       16'h0100
`define RST_DEC        16'h0100
`define RST_ZWD        16'h0000
`define RST_SWM        8'h00
`endif

// File: core/ref_input_sync.v
`timescale 1ns/100ps
`default_nettype none
module ref_input_sync #(
	parameter W = 6
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] raw,
	input  wire [W-1:0] pol,
	output reg  [W-1:0] act_r
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	// polarity is applied after the second stage so stage one feeds nothing else
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_r  <= {W{1'b0}};
			s2_r  <= {W{1'b0}};
			act_r <= {W{1'b0}};
		end
		else
		begin
			s1_r  <= raw;
			s2_r  <= s1_r;
			act_r <= s2_r ^ pol;
		end
	end
endmodule // ref_input_sync
`default_nettype wire

// File: core/step_position_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "ramp_evt_defs.vh"
module step_position_counter (
	input  wire               clk,
	input  wire               rst,
	input  wire signed [23:0] velocity,
	input  wire               block,
	input  wire               load,
	input  wire [31:0]        load_value,
	output reg  [31:0]        position_r,
	output reg                step_r,
	output reg                dir_r
);
	reg  [23:0] acc_r;
	wire [23:0] mag;
	wire [24:0] sum;
	wire        fire;
	assign mag  = velocity[23] ? (~velocity + `VEL_ONE) : velocity;
	assign sum  = {1'b0, acc_r} + {1'b0, mag};
	// carry only counts while speed is nonzero: no accumulator state can step at zero
	assign fire = sum[24] & (mag != 24'h000000) & ~block;
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			acc_r      <= 24'h000000;
			position_r <= 32'h00000000;
			step_r     <= 1'b0;
			dir_r      <= 1'b0;
		end
		else
		begin
			step_r <= fire;
			dir_r  <= velocity[23];
			if (mag != 24'h000000)
				acc_r <= sum[23:0];
			if (load)
				position_r <= load_value;
			else if (fire)
				position_r <= velocity[23] ? position_r - `POS_ONE : position_r + `POS_ONE;
		end
	end
endmodule // step_position_counter
`default_nettype wire

// File: bench/ramp_evt_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// bus and output timing checks
// ****************************************
module ramp_evt_checker (
	input wire logic        CORE_CLK,
	input wire logic        RST,
	input wire logic        HSEL,
	input wire logic [1:0]  HTRANS,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic [1:0]  IRQ,
	input wire logic [1:0]  STEP
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	logic taken;
	assign taken = HSEL && HTRANS[1] && HREADY && HREADYOUT;
	resp_okay_a: assert property (HRESP == 1'b0) else $error("bus response not okay");
	one_wait_a: assert property (taken |=> !HREADYOUT ##1 HREADYOUT) else $error("wait state not exactly one");
	wait_cause_a: assert property ($fell(HREADYOUT) |-> $past(taken)) else $error("wait state without a transfer");
	rdata_hold_a: assert property (!$rose(HREADYOUT) |-> $stable(HRDATA)) else $error("read data moved between transfers");
	irq_clear_a: assert property ($fell(IRQ[0]) |-> !$past(HREADYOUT, 2)) else $error("axis 0 interrupt dropped without a bus read");
	irq_clear_b_a: assert property ($fell(IRQ[1]) |-> !$past(HREADYOUT, 2)) else $error("axis 1 interrupt dropped without a bus read");
	step_pulse_a: assert property (STEP[0] |=> !STEP[0]) else $error("axis 0 step longer than one cycle");
	step_pulse_b_a: assert property (STEP[1] |=> !STEP[1]) else $error("axis 1 step longer than one cycle");
endmodule // ramp_evt_checker
`default_nettype wire

// File: bench/host_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// host side bus master
// ****************************************
module host_mcu_model (
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// entered just after a rising edge; hangs are cut by the bench watchdog
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= w ? d : ~hwdata;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask
endmodule // host_mcu_model
`default_nettype wire

// File: bench/ramp_stop_switch_event_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ramp_stop_switch_event_logic_tb;
	logic        CORE_CLK = 1'b0;
	logic        RST = 1'b1;
	logic        hsel, hwrite, hready;
	logic [1:0]  htrans, ref_l = 2'h0, ref_r = 2'h0, stall_in = 2'h0, irq, step, dir;
	logic [2:0]  hsize;
	logic [3:0]  vel_range;
	logic [31:0] haddr, hwdata, hrdata, q, p;
	int          mismatches = 0;
	int          checks = 0;
	always #5 CORE_CLK = ~CORE_CLK;
	ramp_event_ctrl dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(), .REF_L(ref_l), .REF_R(ref_r), .STALL_IN(stall_in), .IRQ(irq),
		.STEP(step), .DIR(dir), .VEL_RANGE(vel_range));
	host_mcu_model host_u (.clk(CORE_CLK), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// ****************************************
	// shared helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		host_u.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [31:0] a);
		host_u.xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic regs_and_polarity;
		rd(32'h00); chk(q, 32'h3);
		rd(32'h14); chk(q, 32'h100);
		wr(32'h08, 32'h55); rd(32'h08); chk(q, 32'h0);
		rd(32'h80); chk(q, 32'h0);
		wr(32'h04, 32'h1000); rd(32'h04); chk(q, 32'h1000);
		wr(32'h24, 32'h04); rd(32'h2C); chk(q[0], 1'b1);
		chk(irq[0], 1'b0);
		// back to normal polarity, else the next stop enable sees a live switch
		wr(32'h24, 32'h00);
	endtask
	task automatic switch_hard_stop;
		wr(32'h28, 32'h2);
		wr(32'h10, 32'hFFFF); wr(32'h0C, 32'h10000); wr(32'h24, 32'h11); wr(32'h00, 32'h2);
		repeat (3000) @(posedge CORE_CLK);
		ref_l <= 2'h1;
		repeat (10) @(posedge CORE_CLK);
		rd(32'h2C); chk(q[2], 1'b1);
		chk(irq, 2'h1);
		rd(32'h30); p = q; rd(32'h04); chk(q, p);
		chk(p < 32'h1000, 1'b1);
		rd(32'h08); chk(q, 32'h0);
		rd(32'h2C); chk(q[2], 1'b1);
		ref_l <= 2'h0;
		repeat (10) @(posedge CORE_CLK);
		rd(32'h2C); rd(32'h2C); chk(q[2], 1'b0);
		chk(q[9], 1'b1);
		repeat (3) @(posedge CORE_CLK);
		chk(irq[0], 1'b0);
		rd(32'h08); chk(q, 32'h0);
		repeat (400) @(posedge CORE_CLK);
		rd(32'h08); chk(q != 32'h0, 1'b1);
		chk(dir[0], 1'b1);
	endtask
	task automatic hold_and_target;
		wr(32'h00, 32'h3); rd(32'h08); chk(q, 32'h0);
		rd(32'h2C); chk(q[8], 1'b1);
		chk(q[10], 1'b1);
		rd(32'h04); p = q;
		repeat (600) @(posedge CORE_CLK);
		rd(32'h04); chk(q, p);
		wr(32'h20, p + 32'h3); wr(32'h00, 32'h0);
		repeat (2000) @(posedge CORE_CLK);
		rd(32'h04); chk(q, p + 32'h3);
		rd(32'h2C); chk(q[7], 1'b1);
	endtask
	task automatic thresholds_and_stall;
		wr(32'h74, 32'h100); wr(32'h78, 32'h1FF); wr(32'h4C, 32'h180); wr(32'h50, 32'h100);
		wr(32'h40, 32'h1);
		repeat (400) @(posedge CORE_CLK);
		chk(vel_range[3:2], 2'h3);
		rd(32'h48); chk(q, 32'h180);
		wr(32'h64, 32'h40); wr(32'h68, 32'h4);
		stall_in <= 2'h2;
		repeat (10) @(posedge CORE_CLK);
		rd(32'h48); chk(q, 32'h0);
		rd(32'h6C); chk(q[4], 1'b1);
		chk(irq[1], 1'b1);
		stall_in <= 2'h0;
		repeat (10) @(posedge CORE_CLK);
		rd(32'h6C); rd(32'h6C); chk(q[4], 1'b0);
		// host parks the axis inside the zero wait so it cannot restart
		wr(32'h40, 32'h3);
		repeat (600) @(posedge CORE_CLK);
		rd(32'h48); chk(q, 32'h0);
	endtask
	task automatic soft_stop;
		wr(32'h54, 32'h40); wr(32'h5C, 32'h100); wr(32'h64, 32'h82); wr(32'h40, 32'h1);
		repeat (400) @(posedge CORE_CLK);
		ref_r <= 2'h2;
		repeat (10) @(posedge CORE_CLK);
		rd(32'h48); p = q;
		chk(p != 32'h0, 1'b1);
		// two samples exactly one ramp tick apart, both above the transition velocity
		repeat (97) @(posedge CORE_CLK);
		rd(32'h48); chk(p - q, 32'h40);
		repeat (600) @(posedge CORE_CLK);
		rd(32'h48); chk(q, 32'h0);
		rd(32'h6C); chk(q[3], 1'b1);
		chk(irq[1], 1'b1);
	endtask
	initial
	begin
		repeat (6) @(posedge CORE_CLK);
		RST <= 1'b0;
		@(posedge CORE_CLK);
		regs_and_polarity;
		switch_hard_stop;
		hold_and_target;
		thresholds_and_stall;
		soft_stop;
		conclude;
	end
	// ****************************************
	// watchdog, well above the expected 8.3k cycles
	// ****************************************
	initial
	begin
		repeat (60000) @(posedge CORE_CLK);
		mismatches++;
		conclude;
	end
endmodule // ramp_stop_switch_event_logic_tb
bind ramp_event_ctrl ramp_evt_checker chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .STEP(STEP));
`default_nettype wire
